// *** pd_controller.sv ***
// Controller end: AXI4-Lite registers driving register access over process data
`timescale 1ns/1ps
module pd_controller (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   pd_link_if.host link
);

   typedef enum logic [1:0] {st_idle, st_clear, st_wait} ctl_state_e;

   ctl_state_e state_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_write;
   logic [31:0] cmd_w;
   logic [31:0] wval_w;
   logic [6:0] cmd_r;
   logic [15:0] wval_r;
   logic [15:0] rval_r;
   logic [7:0] ack_r;
   logic done_r;
   logic start;
   logic [7:0] ctrl_r;
   logic [15:0] out_word_r;
   logic [7:0] expect_ack;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction : merge

   // ==========================================================
   // AXI4-Lite write channels
   assign do_write = !awready_r && !wready_r && !bvalid_r;
   assign cmd_w = merge({25'h0, cmd_r}, wdata_r, wstrb_r);
   assign wval_w = merge({16'h0000, wval_r}, wdata_r, wstrb_r);
   assign start = do_write && awaddr_r == pdra_pkg::off_cmd && cmd_w[pdra_pkg::cmd_start_bit] && state_r == st_idle;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_r <= 1'b1;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Command and write value registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_r <= 7'h00;
         wval_r <= pdra_pkg::reset_word;
      end else if (do_write && state_r == st_idle) begin
         if (awaddr_r == pdra_pkg::off_cmd) begin
            cmd_r <= cmd_w[6:0];
         end
         if (awaddr_r == pdra_pkg::off_wdata) begin
            wval_r <= wval_w[15:0];
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         unique case (s_axi_araddr)
            pdra_pkg::off_cmd: rdata_r <= {25'h0, cmd_r};
            pdra_pkg::off_wdata: rdata_r <= {16'h0000, wval_r};
            pdra_pkg::off_status: rdata_r <= {16'h0000, ack_r, 6'h00, done_r, state_r != st_idle};
            pdra_pkg::off_rdata: rdata_r <= {16'h0000, rval_r};
            default: rdata_r <= 32'h00000000;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ==========================================================
   // Link sequencer
   assign expect_ack = cmd_r[pdra_pkg::cmd_write_bit] ? (ctrl_r & ~(8'h01 << pdra_pkg::ctrl_write_bit)) : ctrl_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= st_idle;
         ctrl_r <= pdra_pkg::reset_byte;
         out_word_r <= pdra_pkg::reset_word;
         done_r <= 1'b0;
         ack_r <= pdra_pkg::reset_byte;
         rval_r <= pdra_pkg::reset_word;
      end else begin
         unique case (state_r)
            st_idle: begin
               ctrl_r <= pdra_pkg::reset_byte;
               if (start) begin
                  done_r <= 1'b0;
                  state_r <= st_clear;
               end
            end
            st_clear: begin
               if (link.status_byte == pdra_pkg::reset_byte) begin
                  ctrl_r <= {1'b1, cmd_r[pdra_pkg::cmd_write_bit], cmd_r[5:0]};
                  out_word_r <= wval_r;
                  state_r <= st_wait;
               end
            end
            st_wait: begin
               if (link.status_byte == expect_ack) begin
                  ack_r <= link.status_byte;
                  if (!cmd_r[pdra_pkg::cmd_write_bit]) begin
                     rval_r <= link.device_to_host_word;
                  end
                  done_r <= 1'b1;
                  ctrl_r <= pdra_pkg::reset_byte;
                  state_r <= st_idle;
               end
            end
         endcase
      end
   end

   assign link.ctrl_byte = ctrl_r;
   assign link.host_to_device_word = out_word_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = pdra_pkg::axi_okay;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = pdra_pkg::axi_okay;

endmodule : pd_controller

// *** pdra_pkg.sv ***
// Constants shared by the process data register access link and its two ends
package pdra_pkg;

   // ==========================================================
   // Control byte layout
   localparam int ctrl_access_bit = 7;
   localparam int ctrl_write_bit = 6;
   localparam int reg_num_w = 6;
   localparam int reg_count = 64;

   // ==========================================================
   // Register numbers and values
   localparam logic [5:0] reg_fw_version = 6'h09;
   localparam logic [5:0] reg_unlock_code = 6'h1f;
   localparam logic [5:0] reg_feature = 6'h20;
   localparam logic [15:0] unlock_code_value = 16'h1235;
   // Arbitrary neutral value
   localparam logic [15:0] fw_version_default = 16'h4e31;
   localparam logic [15:0] reset_word = 16'h0000;
   localparam logic [7:0] reset_byte = 8'h00;

   // ==========================================================
   // Controller register offsets and fields
   localparam logic [7:0] off_cmd = 8'h00;
   localparam logic [7:0] off_wdata = 8'h04;
   localparam logic [7:0] off_status = 8'h08;
   localparam logic [7:0] off_rdata = 8'h0c;
   localparam int cmd_write_bit = 6;
   localparam int cmd_start_bit = 31;
   localparam int stat_busy_bit = 0;
   localparam int stat_done_bit = 1;
   localparam int stat_ack_lsb = 8;
   localparam logic [1:0] axi_okay = 2'h0;

endpackage : pdra_pkg

// *** pd_link_if.sv ***
// Interface carrying the cyclic process data between controller and terminal
`timescale 1ns/1ps
interface pd_link_if;
   logic [7:0] ctrl_byte;
   logic [15:0] host_to_device_word;
   logic [7:0] status_byte;
   logic [15:0] device_to_host_word;

   modport device (
      input ctrl_byte,
      input host_to_device_word,
      output status_byte,
      output device_to_host_word
   );

   modport host (
      output ctrl_byte,
      output host_to_device_word,
      input status_byte,
      input device_to_host_word
   );
endinterface : pd_link_if

// *** pd_terminal.sv ***
// Terminal end: register bank answering register access through process data
// Function
// - Control bit 7 enables register access
// - Control bit 6: one writes, zero reads
// - Control bits 5..0 select register number
// - Read acknowledge copies control byte exactly
// - Read returns selected register word
// - Output word ignored during reads
// - Controller sends write value with control
// - Write acknowledge clears bit 6 only
// - Controller discards input word after writes
// - Protected: only register 31 writable
// - Code word in register 31 unlocks
// - Other value in register 31 relocks
// - New register 32 values act only after restart
// - Register 9 returns firmware version
// - Register 32 holds feature configuration
// - Register 31 reads back stored code
`timescale 1ns/1ps
module pd_terminal #(
   parameter logic [15:0] fw_version = pdra_pkg::fw_version_default
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   pd_link_if.device link,
   output logic [15:0] active_feature,
   output logic write_protected
);

   // ==========================================================
   // Control byte decode
   logic access;
   logic is_write;
   logic [5:0] reg_num;
   logic locked;
   logic [15:0] store_r [0:pdra_pkg::reg_count-1];
   logic [7:0] status_r;
   logic [15:0] in_word_r;
   logic [15:0] active_feature_r;
   logic write_protected_r;

   assign access = link.ctrl_byte[pdra_pkg::ctrl_access_bit];
   assign is_write = link.ctrl_byte[pdra_pkg::ctrl_write_bit];
   assign reg_num = link.ctrl_byte[pdra_pkg::reg_num_w-1:0];
   assign locked = store_r[pdra_pkg::reg_unlock_code] != pdra_pkg::unlock_code_value;

   function automatic logic writable(input logic [5:0] num, input logic lock);
      writable = (num == pdra_pkg::reg_unlock_code)
         || (!lock && num != pdra_pkg::reg_fw_version);
   endfunction : writable

   function automatic logic [15:0] read_value(input logic [5:0] num, input logic [15:0] word);
      read_value = (num == pdra_pkg::reg_fw_version) ? fw_version : word;
   endfunction : read_value

   // ==========================================================
   // Register store
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < pdra_pkg::reg_count; i++) begin
            store_r[i] <= pdra_pkg::reset_word;
         end
      end else if (access && is_write && writable(reg_num, locked)) begin
         store_r[reg_num] <= link.host_to_device_word;
      end
   end

   // ==========================================================
   // Acknowledge and read answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= pdra_pkg::reset_byte;
         in_word_r <= pdra_pkg::reset_word;
      end else if (access && is_write) begin
         status_r <= link.ctrl_byte & ~(8'h01 << pdra_pkg::ctrl_write_bit);
      end else if (access) begin
         status_r <= link.ctrl_byte;
         in_word_r <= read_value(reg_num, store_r[reg_num]);
      end else begin
         status_r <= pdra_pkg::reset_byte;
         in_word_r <= pdra_pkg::reset_word;
      end
   end

   // ==========================================================
   // Active configuration, loaded on restart only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_feature_r <= pdra_pkg::reset_word;
      end else if (restart) begin
         active_feature_r <= store_r[pdra_pkg::reg_feature];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_protected_r <= 1'b1;
      end else begin
         write_protected_r <= locked;
      end
   end

   assign link.status_byte = status_r;
   assign link.device_to_host_word = in_word_r;
   assign active_feature = active_feature_r;
   assign write_protected = write_protected_r;

endmodule : pd_terminal

// *** pdra_asserts.sv ***
// Checker watching the process data link between controller and terminal
`timescale 1ns/1ps
module pdra_asserts #(
   parameter logic [15:0] fw_version = pdra_pkg::fw_version_default
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] ctrl_byte,
   input wire logic [15:0] host_to_device_word,
   input wire logic [7:0] status_byte,
   input wire logic [15:0] device_to_host_word
);
   // ==========================================================
   // Shadow of code word and feature register
   logic [15:0] code_r;
   logic [15:0] feat_r;
   logic rd_req;
   logic wr_req;
   assign rd_req = ctrl_byte[7] && !ctrl_byte[6];
   assign wr_req = ctrl_byte[7] && ctrl_byte[6];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_r <= 16'h0000;
      end else if (ctrl_byte == {2'b11, pdra_pkg::reg_unlock_code}) begin
         code_r <= host_to_device_word;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         feat_r <= 16'h0000;
      end else if (ctrl_byte == {2'b11, pdra_pkg::reg_feature} && code_r == pdra_pkg::unlock_code_value) begin
         feat_r <= host_to_device_word;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_idle_answer: assert property (!ctrl_byte[7] |=> status_byte == 8'h00 && device_to_host_word == 16'h0000)
      else $error("link answer not idle");
   a_read_ack_copy: assert property (rd_req |=> status_byte == $past(ctrl_byte))
      else $error("read acknowledge differs");
   a_write_ack_clear: assert property (wr_req |=> status_byte == ($past(ctrl_byte) & 8'hbf))
      else $error("write acknowledge differs");
   a_fw_word_read: assert property (ctrl_byte == {2'b10, pdra_pkg::reg_fw_version} |=> device_to_host_word == fw_version)
      else $error("firmware word wrong");
   a_code_read_back: assert property (ctrl_byte == {2'b10, pdra_pkg::reg_unlock_code} |=> device_to_host_word == code_r)
      else $error("code word read back wrong");
   a_feature_guard: assert property (ctrl_byte == {2'b10, pdra_pkg::reg_feature} |=> device_to_host_word == feat_r)
      else $error("feature register content wrong");
   a_read_word_steady: assert property (rd_req && $stable(ctrl_byte) |=> $stable(device_to_host_word))
      else $error("read word moved");
   a_write_word_hold: assert property (wr_req |=> device_to_host_word == $past(device_to_host_word))
      else $error("word changed on write");
   c_fw_read: cover property (ctrl_byte == {2'b10, pdra_pkg::reg_fw_version});
   c_unlock: cover property (ctrl_byte == {2'b11, pdra_pkg::reg_unlock_code} && host_to_device_word == 16'h1235);
   c_feature_write: cover property (ctrl_byte == {2'b11, pdra_pkg::reg_feature} && code_r == 16'h1235);
endmodule : pdra_asserts

// *** testbench.sv ***
// Testbench driving the controller over AXI4-Lite against the terminal
`timescale 1ns/1ps
module testbench;
   logic aclk, aresetn, restart, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, st, rd;
   logic [3:0] wstrb;
   logic [15:0] feat;
   logic wprot;
   int miscompares, checked;
   pd_link_if link();
   pd_controller pd_controller_i(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .link(link));
   pd_terminal pd_terminal_i(.aclk(aclk), .aresetn(aresetn), .restart(restart), .link(link),
      .active_feature(feat), .write_protected(wprot));
   pdra_asserts pdra_asserts_i(.aclk(aclk), .aresetn(aresetn), .ctrl_byte(link.ctrl_byte),
      .host_to_device_word(link.host_to_device_word), .status_byte(link.status_byte),
      .device_to_host_word(link.device_to_host_word));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // ==========================================================
   // Reporting
   task complete_run;
      $display("Mismatches %0d of %0d comparisons", miscompares, checked);
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task timeout;
      miscompares++;
      $display("BAD %0t wait limit reached", $time);
      complete_run();
   endtask : timeout

   // ==========================================================
   // AXI4-Lite master
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      bready <= 1'b0;
      if (!bvalid) timeout();
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      d = rdata;
      rready <= 1'b0;
      if (!rvalid) timeout();
   endtask : axi_read

   // ==========================================================
   // One register transfer over the link
   task automatic pd_op(input logic wr, input logic [5:0] num, input logic [15:0] v);
      int n;
      axi_write(pdra_pkg::off_wdata, {16'h0000, v});
      axi_write(pdra_pkg::off_cmd, {1'b1, 24'h000000, wr, num});
      n = 0;
      do begin
         axi_read(pdra_pkg::off_status, st);
         n++;
      end while (!(st[1] && !st[0]) && n < 30);
      if (!(st[1] && !st[0])) timeout();
      check({30'h0, st[1:0]}, 32'h00000002);
      check({24'h0, st[15:8]}, {24'h0, 2'b10, num});
      axi_read(pdra_pkg::off_rdata, rd);
   endtask : pd_op

   // ==========================================================
   // Scenarios
   task sc_locked;
      check({31'h0, wprot}, 32'h1);
      pd_op(1'b0, pdra_pkg::reg_fw_version, 16'hffff);
      check(rd, {16'h0, pdra_pkg::fw_version_default});
      pd_op(1'b1, pdra_pkg::reg_feature, 16'h0002);
      pd_op(1'b0, pdra_pkg::reg_feature, 16'hffff);
      check(rd, 32'h0);
      pd_op(1'b1, pdra_pkg::reg_fw_version, 16'habcd);
      pd_op(1'b0, pdra_pkg::reg_fw_version, 16'hffff);
      check(rd, {16'h0, pdra_pkg::fw_version_default});
   endtask : sc_locked
   task sc_unlock;
      pd_op(1'b1, pdra_pkg::reg_unlock_code, pdra_pkg::unlock_code_value);
      check({31'h0, wprot}, 32'h0);
      pd_op(1'b0, pdra_pkg::reg_unlock_code, 16'hffff);
      check(rd, 32'h00001235);
      pd_op(1'b1, pdra_pkg::reg_feature, 16'h0002);
      pd_op(1'b0, pdra_pkg::reg_feature, 16'hffff);
      check(rd, 32'h00000002);
      check({16'h0, feat}, 32'h0);
      @(posedge aclk);
      restart <= 1'b1;
      @(posedge aclk);
      restart <= 1'b0;
      repeat (2) @(posedge aclk);
      check({16'h0, feat}, 32'h00000002);
   endtask : sc_unlock
   task sc_relock;
      pd_op(1'b1, pdra_pkg::reg_unlock_code, 16'h0000);
      check({31'h0, wprot}, 32'h1);
      pd_op(1'b1, pdra_pkg::reg_feature, 16'h8001);
      pd_op(1'b0, pdra_pkg::reg_feature, 16'hffff);
      check(rd, 32'h00000002);
      pd_op(1'b0, pdra_pkg::reg_unlock_code, 16'hffff);
      check(rd, 32'h0);
      axi_write(8'h14, 32'hffffffff);
      axi_read(8'h10, rd);
      check(rd, 32'h0);
   endtask : sc_relock

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, restart, aresetn} = 7'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      miscompares = 0;
      checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      sc_locked();
      sc_unlock();
      sc_relock();
      complete_run();
   end
endmodule : testbench
